// File: hdl/cdiv_defs.vh
// Purpose: shared constants for the 2/4/8 clock divider
// Assumes: one system clock; the divided input clock is a sampled pin
// Notes: definitions only
`ifndef CDIV_DEFS_VH
`define CDIV_DEFS_VH
`define CDIV_STAGES 3
`define CDIV_CNT_RESET 3'h0
`define CDIV_SYNC_RESET 2'h0
`define CDIV_ARM_CLK_HIGH 2'h1
`define CDIV_ARM_CLK_LOW 2'h2
`define CDIV_ARM_IDLE 2'h0
`define CDIV_ARM_ONE 2'h1
`endif

// File: hdl/cdiv_sync.v
// Purpose: two flip-flop synchroniser for a bundle of pin inputs
// Assumes: inputs are asynchronous to SYS_CLK
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
`include "cdiv_defs.vh"
module cdiv_sync #(
    parameter WIDTH = 3
) (
    input wire clk,
    input wire rstn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_reg <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // cdiv_sync
`default_nettype wire

// File: hdl/cdiv_top.v
// Purpose: divide-by-2/4/8 chain driven by a sampled input clock
// Assumes: input clock, freeze and reset pins are asynchronous; SYS_CLK much faster
// Notes: input clock edges are detected on synchronised samples
// Notes: CLK_IN high and low phases must each span at least three SYS_CLK cycles
// Notes: outputs follow a counted CLK_IN rise by three SYS_CLK edges
//
// Contract
// - reset released with clock high: outputs start after second rising edge.
// - reset released with clock low: outputs start after third rising edge.
// - freeze high stalls dividers at next falling input clock edge.
// - while stalled, all divider bits and outputs hold their state.
// - freeze low resumes counting at next falling edge, from held count.
// - freeze sampled by flop on falling input clock edge only.
// - reset high holds all divider bits in reset state.
`timescale 1ns/1ps
`default_nettype none
`include "cdiv_defs.vh"
module cdiv_top #(
    parameter STAGES = `CDIV_STAGES
) (
    // system
    input wire SYS_CLK,
    input wire RSTN,
    // pins from the clock source and control logic
    input wire CLK_IN,
    input wire FREEZE,
    input wire DIVIDER_RESET,
    // divided outputs
    output reg HALF_RATE_OUT,
    output reg QUARTER_RATE_OUT,
    output reg EIGHTH_RATE_OUT
);
    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    wire [2:0] pins_sync;
    cdiv_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .din({DIVIDER_RESET, FREEZE, CLK_IN}),
        .dout(pins_sync)
    );
    // ---------------------------------------------------------------
    // synchronised pin views
    // ---------------------------------------------------------------
    wire clk_s = pins_sync[0];
    wire freeze_s = pins_sync[1];
    wire dreset_s = pins_sync[2];

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // level change between two samples in the wanted direction
    function edge_of;
        input now_level;
        input was_level;
        input want_high;
        begin
            if (want_high)
                edge_of = now_level & ~was_level;
            else
                edge_of = ~now_level & was_level;
        end
    endfunction

    // rising edges to swallow, judged on the clock level at release
    function [1:0] arm_load;
        input level_high;
        begin
            if (level_high)
                arm_load = `CDIV_ARM_CLK_HIGH;
            else
                arm_load = `CDIV_ARM_CLK_LOW;
        end
    endfunction

    // one swallowed rise per detected edge, never below idle
    function [1:0] arm_step;
        input [1:0] arm;
        input edge_seen;
        begin
            if (edge_seen && arm != `CDIV_ARM_IDLE)
                arm_step = arm - `CDIV_ARM_ONE;
            else
                arm_step = arm;
        end
    endfunction

    // ---------------------------------------------------------------
    // edge detection on the synchronised pins
    // ---------------------------------------------------------------
    reg clk_d_reg;
    reg dreset_d_reg;
    wire rise = edge_of(clk_s, clk_d_reg, 1'b1);
    wire fall = edge_of(clk_s, clk_d_reg, 1'b0);
    wire release_ev = edge_of(dreset_s, dreset_d_reg, 1'b0);

    always @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            clk_d_reg <= 1'b0;
            dreset_d_reg <= 1'b0;
        end
        else
        begin
            clk_d_reg <= clk_s;
            dreset_d_reg <= dreset_s;
        end
    end

    // ---------------------------------------------------------------
    // start-up gate after divider reset release
    // ---------------------------------------------------------------
    reg [1:0] arm_reg;
    reg [1:0] arm_next;

    // a rise seen in the release cycle is one of the swallowed edges
    always @*
    begin
        arm_next = arm_reg;
        if (dreset_s)
            arm_next = `CDIV_ARM_IDLE;
        else if (release_ev)
            arm_next = arm_step(arm_load(clk_s), rise);
        else
            arm_next = arm_step(arm_reg, rise);
    end

    always @(posedge SYS_CLK)
    begin
        if (!RSTN)
            arm_reg <= `CDIV_ARM_IDLE;
        else
            arm_reg <= arm_next;
    end

    // ---------------------------------------------------------------
    // freeze flop, loaded on falling input clock edges, cleared while divider reset is high
    // ---------------------------------------------------------------
    reg stall_reg;
    reg stall_next;

    always @*
    begin
        stall_next = stall_reg;
        if (dreset_s)
            stall_next = 1'b0;
        else if (fall)
            stall_next = freeze_s;
    end

    always @(posedge SYS_CLK)
    begin
        if (!RSTN)
            stall_reg <= 1'b0;
        else
            stall_reg <= stall_next;
    end

    // ---------------------------------------------------------------
    // divider chain: one toggle stage per output, common enable
    // ---------------------------------------------------------------
    localparam [STAGES-1:0] CNT_INIT = `CDIV_CNT_RESET;

    reg [STAGES-1:0] cnt_reg;
    wire [STAGES-1:0] cnt_next;
    wire [STAGES:0] carry;
    // counted rise: not stalled, not swallowed, not in the release cycle
    wire count_en;

    assign count_en = rise & ~stall_reg & ~release_ev & (arm_reg == `CDIV_ARM_IDLE);
    assign carry[0] = count_en;

    genvar g;
    generate
        for (g = 0; g < STAGES; g = g + 1)
        begin : g_stage
            // a stage toggles on a counted rise when every lower stage is high, else holds
            assign carry[g+1] = carry[g] & cnt_reg[g];
            assign cnt_next[g] = dreset_s ? CNT_INIT[g] : (cnt_reg[g] ^ carry[g]);
        end
    endgenerate

    always @(posedge SYS_CLK)
    begin
        if (!RSTN)
            cnt_reg <= CNT_INIT;
        else
            cnt_reg <= cnt_next;
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    // outputs mirror the divider bits, so common edges coincide
    always @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            HALF_RATE_OUT <= 1'b0;
            QUARTER_RATE_OUT <= 1'b0;
            EIGHTH_RATE_OUT <= 1'b0;
        end
        else
        begin
            HALF_RATE_OUT <= cnt_next[0];
            QUARTER_RATE_OUT <= cnt_next[1];
            EIGHTH_RATE_OUT <= cnt_next[2];
        end
    end
endmodule // cdiv_top
`default_nettype wire

// File: dv/cdiv_src.sv
// Purpose: input clock. Assumes: 600 ns phases. Notes: free running
`timescale 1ns/1ps
`default_nettype none
module cdiv_src (output logic clk_in);
    initial clk_in = 1'h0;
    always #600 clk_in = ~clk_in;
endmodule // cdiv_src
`default_nettype wire

// File: dv/cdiv_props.sv
// Purpose: port checks. Assumes: CLK_IN phases of 6 SYS_CLK. Notes: bound in
`timescale 1ns/1ps
`default_nettype none
module cdiv_props (input wire logic SYS_CLK, RSTN, CLK_IN, FREEZE, DIVIDER_RESET,
    HALF_RATE_OUT, QUARTER_RATE_OUT, EIGHTH_RATE_OUT);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    chk_rst_zero: assert property ($past(DIVIDER_RESET, 5) && $past(DIVIDER_RESET, 4)
        |-> !(HALF_RATE_OUT | QUARTER_RATE_OUT | EIGHTH_RATE_OUT)) else $error("not clear");
    chk_half_rise: assert property ($rose(HALF_RATE_OUT) |-> $past(CLK_IN, 3) && !$past(CLK_IN, 4))
        else $error("half");
    chk_qtr_align: assert property ($rose(QUARTER_RATE_OUT) |-> $fell(HALF_RATE_OUT))
        else $error("quarter");
    chk_oct_align: assert property ($rose(EIGHTH_RATE_OUT) |-> $fell(QUARTER_RATE_OUT))
        else $error("eighth");
    chk_frz_hold: assert property ($past(FREEZE, 18) && $past(FREEZE) |-> $stable(HALF_RATE_OUT))
        else $error("moved");
    chk_start_late: assert property ($fell(DIVIDER_RESET) |-> !HALF_RATE_OUT [*8])
        else $error("early");
    chk_frz_resume: assert property ($fell(FREEZE) |-> ##[1:40] $changed(HALF_RATE_OUT))
        else $error("stuck");
    chk_frz_fall: assert property ($rose(FREEZE) && !CLK_IN && !$past(CLK_IN, 4)
        |-> ##[1:14] $changed(HALF_RATE_OUT)) else $error("stalled");
endmodule // cdiv_props
bind cdiv_top cdiv_props chk_u (.*);
`default_nettype wire

// File: dv/tb_cdiv_top.sv
// Purpose: divider bench. Assumes: 10 MHz SYS_CLK. Notes: counts kept here
`timescale 1ns/1ps
`default_nettype none
module tb_cdiv_top;
    logic SYS_CLK = 1'h0, RSTN = 1'h0, FREEZE = 1'h0, DIVIDER_RESET = 1'h1;
    logic [2:0] cnt;
    wire logic clk_in;
    wire logic [2:0] o;
    int num_errors = 0, checks = 0, cyc = 0;
    cdiv_src src_u (.clk_in(clk_in));
    cdiv_top dut_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_IN(clk_in), .FREEZE(FREEZE),
        .DIVIDER_RESET(DIVIDER_RESET), .HALF_RATE_OUT(o[0]), .QUARTER_RATE_OUT(o[1]), .EIGHTH_RATE_OUT(o[2]));
    initial forever #50 SYS_CLK = ~SYS_CLK;
    task tick(input int n); repeat (n) @(posedge SYS_CLK); #1; endtask
    task rise(input int n); repeat (n) @(posedge clk_in); tick(8); endtask
    task chk(input logic [2:0] seen, input logic [2:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t out %h exp %h", $time, seen, exp);
        end
    endtask
    task t_start(input logic lvl); // release at a chosen clock level
        DIVIDER_RESET = 1'h1;
        tick(8);
        chk(o, 3'h0);
        if (lvl) @(posedge clk_in); else @(negedge clk_in);
        tick(2);
        DIVIDER_RESET = 1'h0;
        for (int k = 1; k < 11; k++)
        begin
            rise(1);
            cnt = (k < 3 - lvl) ? 3'h0 : 3'(k - 2 + lvl);
            chk(o, cnt);
        end
    endtask
    task t_freeze; // set in a low phase, so the next rise still counts
        @(negedge clk_in);
        tick(5);
        FREEZE = 1'h1;
        rise(1);
        cnt = cnt + 3'h2; // rise before the wait, then the one after freeze
        chk(o, cnt);
        rise(4);
        chk(o, cnt);
        FREEZE = 1'h0;
        rise(3);
        chk(o, cnt + 3'h2);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge SYS_CLK)
        if (++cyc == 3000)
        begin
            num_errors++;
            results;
        end
    initial
    begin
        tick(5);
        RSTN = 1'h1;
        t_start(1'h0);
        t_start(1'h1);
        t_freeze;
        results;
    end
endmodule // tb_cdiv_top
`default_nettype wire
